// ### hdl/cab_pkg.sv
/*
 * Shared constants and types for the add and bit-operation execution block.
 * Assumes a decoder that presents one operation per instruction cycle.
 */
package cab_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int REGS = 128;
    // Flag positions inside the status vector o_flags
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_NIBBLE = 1;
    localparam int FLAG_ZERO = 2;
    // Carry positions of the adder
    localparam int NIBBLE_MSB = 3;
    localparam int BYTE_MSB = 7;
    // Values after reset
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    // Skip costs one extra cycle: two cycles in total
    localparam int SKIP_TCY = 2;

    typedef enum logic [3:0] {
        CAB_NOP,
        CAB_ADD_IMMEDIATE_OP,
        CAB_ADD_REGISTER_OP,
        CAB_AND_IMMEDIATE_OP,
        CAB_AND_REGISTER_OP,
        CAB_BIT_CLEAR_OP,
        CAB_BIT_SET_OP,
        CAB_SKIP_IF_BIT_ONE_OP,
        CAB_SKIP_IF_BIT_ZERO_OP
    } cab_op_t;

    typedef enum logic {
        CAB_RUN,
        CAB_SKIP
    } cab_state_t;
endpackage : cab_pkg

// ### hdl/cab_regfile.sv
/*
 * File register memory: 128 bytes, one write port and one registered read.
 * Assumes the caller presents the read address one cycle before use.
 */
module cab_regfile #(
    parameter int DEPTH = cab_pkg::REGS,
    parameter int AW = cab_pkg::ADDR_W,
    parameter int DW = cab_pkg::DATA_W
) (
    input wire logic i_clk,           // Core clock
    input wire logic i_we,            // Write strobe
    input wire logic [AW-1:0] i_waddr, // Write address
    input wire logic [DW-1:0] i_wdata, // Write data
    input wire logic [AW-1:0] i_raddr, // Read address
    output logic [DW-1:0] o_rdata     // Registered read data
);
    logic [DW-1:0] mem [DEPTH];

    initial begin
        if (DEPTH != (1 << AW)) $error("cab_regfile: depth must be 2**AW");
    end

    // Read before write, read registered; no reset on storage to keep it RAM
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : cab_regfile

// ### hdl/cab_core.sv
/*
 * Execution block for add, AND, bit set/clear and bit-test skip operations.
 * Assumes a decoder presenting one operation per cycle on i_valid, with the
 * file address also driven on i_pre_addr one cycle early for the memory read.
 */
module cab_core #(
    parameter int ADDR_W = cab_pkg::ADDR_W,
    parameter logic [6:0] PORT_ADDR = 7'h06,  // I/O port register address
    parameter logic [6:0] TIMER_ADDR = 7'h01  // Timer count register address
) (
    input wire logic i_clk,                     // Core clock, 250 MHz
    input wire logic i_sys_rst,                 // Synchronous reset, high
    input wire logic i_valid,                   // Operation present this cycle
    input wire cab_pkg::cab_op_t i_op,          // Decoded operation
    input wire logic [ADDR_W-1:0] i_pre_addr,   // File address, one cycle early
    input wire logic [ADDR_W-1:0] i_addr,       // File address of this operation
    input wire logic i_dest,                    // Destination select
    input wire logic [7:0] i_imm,               // Immediate operand
    input wire logic [2:0] i_bit,               // Bit index
    input wire logic [7:0] i_port_pins,         // Port pin levels, asynchronous
    input wire logic i_prescale_to_timer,       // Prescaler assigned to timer
    output logic [7:0] o_acc,                   // Accumulator
    output logic [2:0] o_flags,                 // Zero, nibble carry, carry
    output logic o_file_we,                     // File write strobe (mirror)
    output logic [ADDR_W-1:0] o_file_addr,      // File write address
    output logic [7:0] o_file_data,             // File write data
    output logic o_nop_slot,                    // Current slot executes as NOP
    output logic o_prescale_clr                 // Timer prescaler clear pulse
);
    initial begin
        if (ADDR_W != cab_pkg::ADDR_W) $error("cab_core: ADDR_W must be 7");
    end

    logic [7:0] mem_rdata;
    logic [7:0] pin_meta_r, pin_sync_r;
    logic [7:0] acc_r, acc_nxt;
    logic [2:0] flags_r, flags_nxt;
    logic we_r, we_nxt;
    logic [ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic clr_r, clr_nxt;
    cab_pkg::cab_state_t state_r, state_nxt;
    logic [7:0] opnd, sum_lo, res;
    logic [8:0] sum;
    logic [4:0] nib;
    logic bitval, live;

    cab_regfile u_mem (
        .i_clk(i_clk),
        .i_we(we_nxt),
        .i_waddr(waddr_nxt),
        .i_wdata(wdata_nxt),
        .i_raddr(i_pre_addr),
        .o_rdata(mem_rdata)
    );

    // Pins are asynchronous to the core, two stages before use
    always_ff @(posedge i_clk) begin
        pin_meta_r <= i_port_pins;
        pin_sync_r <= pin_meta_r;
    end

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction : bit_mask

    // port operand
    // Pins stand in for the port latch as the source operand
    always_comb begin
        opnd = (i_addr == PORT_ADDR) ? pin_sync_r : mem_rdata;
    end

    always_comb begin
        sum = {1'b0, acc_r} + {1'b0, (i_op == cab_pkg::CAB_ADD_IMMEDIATE_OP) ? i_imm : opnd};
        nib = {1'b0, acc_r[cab_pkg::NIBBLE_MSB:0]}
            + {1'b0, ((i_op == cab_pkg::CAB_ADD_IMMEDIATE_OP) ? i_imm[3:0] : opnd[3:0])};
        sum_lo = sum[7:0];
        bitval = opnd[i_bit];
        live = i_valid && (state_r == cab_pkg::CAB_RUN);
    end

    // Execute: compute next accumulator, flags, file write and skip state
    always_comb begin
        acc_nxt = acc_r;
        flags_nxt = flags_r;
        we_nxt = 1'b0;
        waddr_nxt = i_addr;
        wdata_nxt = 8'h00;
        clr_nxt = 1'b0;
        state_nxt = cab_pkg::CAB_RUN;
        res = 8'h00;
        if (live) begin
            case (i_op)
                cab_pkg::CAB_ADD_IMMEDIATE_OP: begin
                    acc_nxt = sum_lo;
                    flags_nxt = {sum_lo == 8'h00, nib[4], sum[8]};
                end
                cab_pkg::CAB_ADD_REGISTER_OP: begin
                    res = sum_lo;
                    flags_nxt = {sum_lo == 8'h00, nib[4], sum[8]};
                    if (i_dest) begin
                        we_nxt = 1'b1;
                        wdata_nxt = res;
                    end else begin
                        acc_nxt = res;
                    end
                end
                cab_pkg::CAB_AND_IMMEDIATE_OP: begin
                    acc_nxt = acc_r & i_imm;
                    flags_nxt[cab_pkg::FLAG_ZERO] = (acc_r & i_imm) == 8'h00;
                end
                cab_pkg::CAB_AND_REGISTER_OP: begin
                    res = acc_r & opnd;
                    flags_nxt[cab_pkg::FLAG_ZERO] = res == 8'h00;
                    if (i_dest) begin
                        we_nxt = 1'b1;
                        wdata_nxt = res;
                    end else begin
                        acc_nxt = res;
                    end
                end
                cab_pkg::CAB_BIT_CLEAR_OP: begin
                    we_nxt = 1'b1;
                    wdata_nxt = opnd & ~bit_mask(i_bit);
                end
                cab_pkg::CAB_BIT_SET_OP: begin
                    we_nxt = 1'b1;
                    wdata_nxt = opnd | bit_mask(i_bit);
                end
                cab_pkg::CAB_SKIP_IF_BIT_ONE_OP: begin
                    if (bitval) state_nxt = cab_pkg::CAB_SKIP;
                end
                cab_pkg::CAB_SKIP_IF_BIT_ZERO_OP: begin
                    if (!bitval) state_nxt = cab_pkg::CAB_SKIP;
                end
                default: begin
                end
            endcase
            if (we_nxt && (i_addr == TIMER_ADDR) && i_prescale_to_timer) clr_nxt = 1'b1;
        end
    end

    // Register state; the skipped slot always returns to run
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            acc_r <= cab_pkg::ACC_RST;
            flags_r <= cab_pkg::FLAGS_RST;
            we_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= 8'h00;
            clr_r <= 1'b0;
            state_r <= cab_pkg::CAB_RUN;
        end else begin
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            we_r <= we_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            clr_r <= clr_nxt;
            state_r <= state_nxt;
        end
    end

    assign o_acc = acc_r;
    assign o_flags = flags_r;
    assign o_file_we = we_r;
    assign o_file_addr = waddr_r;
    assign o_file_data = wdata_r;
    assign o_nop_slot = (state_r == cab_pkg::CAB_SKIP);
    assign o_prescale_clr = clr_r;

    chk_add_imm_acc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_ADD_IMMEDIATE_OP |=> o_acc == 8'($past(acc_r) + $past(i_imm)))
        else $error("add immediate result wrong");
    chk_add_carry_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_ADD_IMMEDIATE_OP && (9'(acc_r) + 9'(i_imm)) > 9'h0FF
        |=> o_flags[cab_pkg::FLAG_CARRY] && o_flags[cab_pkg::FLAG_ZERO] == (o_acc == 8'h00))
        else $error("carry or zero flag wrong");
    chk_add_reg_dest: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_ADD_REGISTER_OP && i_dest
        |=> o_file_we && $stable(o_acc) && o_file_data == 8'($past(acc_r) + $past(opnd)))
        else $error("add to register destination wrong");
    chk_and_imm_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_AND_IMMEDIATE_OP
        |=> o_flags[1:0] == $past(flags_r[1:0]) && o_acc == ($past(acc_r) & $past(i_imm)))
        else $error("and immediate wrong");
    chk_and_reg_acc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_AND_REGISTER_OP && !i_dest
        |=> !o_file_we && o_acc == ($past(acc_r) & $past(opnd)))
        else $error("and register to accumulator wrong");
    chk_bit_clear_val: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_BIT_CLEAR_OP
        |=> o_file_we && !o_file_data[$past(i_bit)] && $stable(o_flags))
        else $error("bit clear wrong");
    chk_bit_set_val: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_BIT_SET_OP
        |=> o_file_we && o_file_data[$past(i_bit)] && $stable(o_flags))
        else $error("bit set wrong");
    chk_skip_one_slot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_SKIP_IF_BIT_ONE_OP && bitval |=> o_nop_slot ##1 !o_nop_slot)
        else $error("skip if one slot wrong");
    chk_skip_zero_none: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        live && i_op == cab_pkg::CAB_SKIP_IF_BIT_ZERO_OP |=> o_nop_slot == !$past(bitval))
        else $error("skip if zero wrong");
endmodule : cab_core

// ### sim/tb.sv
/*
 * Self-checking bench for the add, AND, bit set/clear and skip execution block.
 * Assumes the block's memory starts unknown, so every register is first
 * cleared through the block itself before random traffic begins.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] PORT_A = 7'h06;
    localparam logic [6:0] TIMER_A = 7'h01;

    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_valid = 1'b0;
    cab_pkg::cab_op_t i_op = cab_pkg::CAB_NOP;
    logic [6:0] i_pre_addr = 7'h00;
    logic [6:0] i_addr = 7'h00;
    logic i_dest = 1'b0;
    logic [7:0] i_imm = 8'h00;
    logic [2:0] i_bit = 3'h0;
    logic [7:0] i_port_pins = 8'h00;
    logic i_prescale_to_timer = 1'b0;
    logic [7:0] o_acc;
    logic [2:0] o_flags;
    logic o_file_we;
    logic [6:0] o_file_addr;
    logic [7:0] o_file_data;
    logic o_nop_slot;
    logic o_prescale_clr;
    int fail_count = 0;
    int checks_done = 0;
    integer seed = 32'hA42FCFA6;
    // Reference model state: accumulator, flag bits, file memory, pin levels
    int m_acc;
    int m_flags;
    int mem [128];
    int pins;
    // Immediates that walk the carry, nibble carry and zero boundaries
    logic [7:0] edge_k [6] = '{8'h01, 8'hFF, 8'h0F, 8'h01, 8'h80, 8'h80};

    cab_core #(.PORT_ADDR(PORT_A), .TIMER_ADDR(TIMER_A)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_op(i_op),
        .i_pre_addr(i_pre_addr), .i_addr(i_addr), .i_dest(i_dest), .i_imm(i_imm),
        .i_bit(i_bit), .i_port_pins(i_port_pins), .i_prescale_to_timer(i_prescale_to_timer),
        .o_acc(o_acc), .o_flags(o_flags), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
        .o_file_data(o_file_data), .o_nop_slot(o_nop_slot), .o_prescale_clr(o_prescale_clr)
    );

    // Free-running core clock, 4 ns period
    always #2 i_clk = ~i_clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // Model of an 8-bit add: carry from bit 7, nibble carry from bit 3
    function automatic int add8(input int opnd);
        int s;
        s = m_acc + opnd;
        m_flags = ((s & 255) == 0 ? 4 : 0) | (((m_acc & 15) + (opnd & 15)) > 15 ? 2 : 0) | (s > 255 ? 1 : 0);
        return s & 255;
    endfunction : add8

    // One operation, preceded by an idle slot so a read never follows its own write
    task automatic exec(input cab_pkg::cab_op_t op, input logic [6:0] a, input logic d,
                        input logic [7:0] k, input logic [2:0] b, input logic pt);
        int rd;
        int r;
        int we;
        int skip;
        bit imm_op;
        rd = (a == PORT_A) ? pins : mem[a];
        r = 0;
        we = 0;
        skip = 0;
        imm_op = (op == cab_pkg::CAB_ADD_IMMEDIATE_OP) || (op == cab_pkg::CAB_AND_IMMEDIATE_OP);
        i_pre_addr = a;
        @(posedge i_clk);
        #1;
        i_valid = 1'b1;
        i_op = op;
        i_addr = a;
        i_dest = d;
        i_imm = k;
        i_bit = b;
        i_prescale_to_timer = pt;
        @(posedge i_clk);
        #1;
        case (op)
            cab_pkg::CAB_ADD_IMMEDIATE_OP, cab_pkg::CAB_ADD_REGISTER_OP: begin
                r = add8(imm_op ? int'(k) : rd);
            end
            cab_pkg::CAB_AND_IMMEDIATE_OP, cab_pkg::CAB_AND_REGISTER_OP: begin
                r = m_acc & (imm_op ? int'(k) : rd);
                m_flags = (m_flags & 3) | (r == 0 ? 4 : 0);
            end
            cab_pkg::CAB_BIT_CLEAR_OP: begin
                r = rd & ~(1 << b);
                we = 1;
            end
            cab_pkg::CAB_BIT_SET_OP: begin
                r = rd | (1 << b);
                we = 1;
            end
            cab_pkg::CAB_SKIP_IF_BIT_ONE_OP: skip = (rd >> b) & 1;
            cab_pkg::CAB_SKIP_IF_BIT_ZERO_OP: skip = ((rd >> b) & 1) ^ 1;
            default: ;
        endcase
        if (op inside {cab_pkg::CAB_ADD_IMMEDIATE_OP, cab_pkg::CAB_ADD_REGISTER_OP,
                       cab_pkg::CAB_AND_IMMEDIATE_OP, cab_pkg::CAB_AND_REGISTER_OP}) begin
            if (imm_op || !d) m_acc = r;
            else we = 1;
        end
        if (we) mem[a] = r;
        check(o_acc, 8'(m_acc));
        check({5'h00, o_flags}, 8'(m_flags));
        check({7'h00, o_file_we}, 8'(we));
        if (we) begin
            check({1'b0, o_file_addr}, {1'b0, a});
            check(o_file_data, 8'(r));
        end
        check({7'h00, o_prescale_clr}, 8'(we && a == TIMER_A && pt));
        check({7'h00, o_nop_slot}, 8'(skip));
        // A skip test is always followed back to back by an add, discarded or not
        if (op inside {cab_pkg::CAB_SKIP_IF_BIT_ONE_OP, cab_pkg::CAB_SKIP_IF_BIT_ZERO_OP}) begin
            i_op = cab_pkg::CAB_ADD_IMMEDIATE_OP;
            i_imm = ~k;
            @(posedge i_clk);
            #1;
            if (!skip) m_acc = add8(255 - int'(k));
            check(o_acc, 8'(m_acc));
            check({5'h00, o_flags}, 8'(m_flags));
            check({7'h00, o_nop_slot}, 8'h00);
        end
        i_valid = 1'b0;
    endtask : exec

    task automatic set_pins(input logic [7:0] v);
        i_port_pins = v;
        pins = v;
        repeat (3) @(posedge i_clk);
        #1;
    endtask : set_pins

    // Hang guard, far beyond the at most 1500 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        give_verdict();
    end

    initial begin
        logic [6:0] a;
        m_acc = 0;
        m_flags = 0;
        foreach (mem[i]) mem[i] = 0;
        repeat (20) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        check(o_acc, 8'h00);
        check({5'h00, o_flags}, 8'h00);
        check({7'h00, o_nop_slot}, 8'h00);
        set_pins(8'hA5);
        // Clearing through an AND with zero works even on unknown memory
        exec(cab_pkg::CAB_AND_IMMEDIATE_OP, 7'h00, 1'b0, 8'h00, 3'h0, 1'b0);
        for (int i = 0; i < 128; i++) exec(cab_pkg::CAB_AND_REGISTER_OP, 7'(i), 1'b1, 8'h00, 3'h0, 1'b1);
        // Carry, nibble carry and zero boundaries
        foreach (edge_k[j]) begin
            exec(cab_pkg::CAB_ADD_IMMEDIATE_OP, 7'h00, 1'b0, edge_k[j], 3'h0, 1'b0);
        end
        for (int n = 0; n < 400; n++) begin
            if (n == 200) set_pins(8'($random(seed)));
            if (n == 300) begin
                i_sys_rst = 1'b1;
                @(posedge i_clk);
                #1;
                i_sys_rst = 1'b0;
                m_acc = 0;
                m_flags = 0;
                check(o_acc, 8'h00);
                check({5'h00, o_flags}, 8'h00);
                repeat (2) @(posedge i_clk);
                #1;
            end
            // Even passes stay in a few low registers, reaching the port and timer often
            a = n[0] ? 7'($random(seed)) : 7'($unsigned($random(seed)) % 8);
            exec(cab_pkg::cab_op_t'(4'($unsigned($random(seed)) % 9)), a, 1'($random(seed)),
                 8'($random(seed)), 3'($random(seed)), 1'($random(seed)));
        end
        give_verdict();
    end
endmodule : tb
